/* src/prp_read_port.sv */
// Registered PROM read port with initialize word and programming modes
//
// Function
// - 2048 words of 8 bits, registered output
// - Power-up high impedance per enable mode
// - Word moves master to slave on clock
// - Asynchronous mode: enable high floats outputs
// - Synchronous mode: float at edge after high
// - Synchronous mode: drive after edge with low
// - Outputs hold between edges; inputs free
// - Register clocked by ungated system clock
// - Initialize loads extra word into both stages
// - Extra word loaded bit for bit
// - Initialized word shows once enable low in asynchronous mode
// - Extra word reads zero as delivered
// - High voltage on programming pin: program inhibit
// - Extra word selected by high-voltage address
// - Asynchronous until mode cell is programmed
// - Erased state zero; programming sets ones
`timescale 1ns/1ns
`include "prp_params.svh"

module prp_read_port
  import prp_pkg::*;
#(
  parameter int ADDR_W      = `PRP_ADDR_W,
  parameter int DATA_W      = `PRP_DATA_W,
  parameter int DEPTH       = `PRP_DEPTH,
  parameter int PGM_MIN_CYC = `PRP_PGM_MIN_CYC
) (
  input  wire logic              CLK_IN,
  input  wire logic              RST_N_IN,
  input  wire logic [ADDR_W-1:0] WORD_ADDRESS_IN,
  input  wire logic              ADDR1_HIGHVOLT_IN,
  input  wire logic              CLOCK_PROGRAM_PIN_IN,
  input  wire logic              ENABLE_VERIFY_N_IN,
  input  wire logic              PRESET_HIGHVOLT_PIN_IN,
  input  wire logic              PROGRAMMING_HIGH_VOLTAGE_IN,
  input  wire logic [DATA_W-1:0] REGISTERED_OUTPUTS_IN,
  output logic      [DATA_W-1:0] REGISTERED_OUTPUTS_OUT,
  output logic                   REGISTERED_OUTPUTS_OE_N_OUT
);

  initial begin
    if (ADDR_W <= `PRP_SEL_BIT || DATA_W < 1 || PGM_MIN_CYC < 1 ||
        DEPTH > (1 << ADDR_W)) begin
      $error("prp_read_port: unsupported parameters");
    end
  end

  localparam int SYNC_W = ADDR_W + DATA_W + 5;
  localparam int CNT_W  = $clog2(PGM_MIN_CYC + 1) + 1;
  localparam logic [CNT_W-1:0] PGM_MIN = CNT_W'(PGM_MIN_CYC);
  localparam logic [SYNC_W-1:0] PIN_IDLE = SYNC_W'(`PRP_PIN_IDLE);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] pin_meta_q;
  logic [SYNC_W-1:0] pin_sync_q;
  logic [SYNC_W-1:0] pin_raw;

  assign pin_raw = {WORD_ADDRESS_IN, REGISTERED_OUTPUTS_IN, ADDR1_HIGHVOLT_IN,
                    CLOCK_PROGRAM_PIN_IN, ENABLE_VERIFY_N_IN,
                    PRESET_HIGHVOLT_PIN_IN, PROGRAMMING_HIGH_VOLTAGE_IN};

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      // Idle levels: no false enable, initialize or edge after reset
      pin_meta_q <= PIN_IDLE;
      pin_sync_q <= PIN_IDLE;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic              a1_hv_s;
  logic              clkpgm_s;
  logic              oe_n_s;
  logic              init_n_s;
  logic              hv_s;

  assign {addr_s, data_s, a1_hv_s, clkpgm_s, oe_n_s, init_n_s, hv_s} = pin_sync_q;

  // ----------------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] mem_rdata;
  logic              mem_we;

  prp_array #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W),
    .DEPTH  (DEPTH)
  ) u_array (
    .clk_in      (CLK_IN),
    .rd_addr_in  (addr_s),
    .rd_data_out (mem_rdata),
    .wr_en_in    (mem_we),
    .wr_addr_in  (addr_s),
    .wr_data_in  (data_s)
  );

  // ----------------------------------------------------------------------
  // Programming state
  // ----------------------------------------------------------------------
  prp_mode_t         mode_q;
  prp_mode_t         mode_d;
  logic [CNT_W-1:0]  pulse_cnt_q;
  logic [CNT_W-1:0]  pulse_cnt_d;
  logic [DATA_W-1:0] init_word_q;
  logic [DATA_W-1:0] init_word_d;
  logic              sync_cell_q;
  logic              sync_cell_d;
  logic              commit;
  logic              sel_extra;
  logic              sel_cell;

  always_comb begin
    mode_d      = mode_q;
    pulse_cnt_d = pulse_cnt_q;
    init_word_d = init_word_q;
    sync_cell_d = sync_cell_q;
    commit      = 1'b0;
    sel_cell    = a1_hv_s && addr_s[`PRP_SEL_BIT];
    sel_extra   = a1_hv_s && !addr_s[`PRP_SEL_BIT];
    if (!hv_s) begin
      mode_d      = PRP_MODE_READ;
      pulse_cnt_d = '0;
    end else begin
      case (mode_q)
        PRP_MODE_READ: begin
          mode_d = PRP_MODE_INHIBIT;
        end
        PRP_MODE_INHIBIT: begin
          pulse_cnt_d = '0;
          if (!clkpgm_s) begin
            mode_d = PRP_MODE_PULSE;
          end
        end
        PRP_MODE_PULSE: begin
          if (pulse_cnt_q < PGM_MIN) begin
            pulse_cnt_d = pulse_cnt_q + CNT_W'(1);
          end
          if (clkpgm_s) begin
            mode_d = PRP_MODE_INHIBIT;
            commit = (pulse_cnt_q >= PGM_MIN);
          end
        end
        default: begin
          mode_d = PRP_MODE_READ;
        end
      endcase
    end
    if (commit && sel_extra) begin
      init_word_d = init_word_q | data_s;
    end
    if (commit && sel_cell) begin
      sync_cell_d = 1'b1;
    end
  end

  assign mem_we = commit && !a1_hv_s;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_q      <= PRP_MODE_READ;
      pulse_cnt_q <= '0;
      init_word_q <= `PRP_INIT_WORD_RST;
      sync_cell_q <= `PRP_SYNC_CELL_RST;
    end else begin
      mode_q      <= mode_d;
      pulse_cnt_q <= pulse_cnt_d;
      init_word_q <= init_word_d;
      sync_cell_q <= sync_cell_d;
    end
  end

  // ----------------------------------------------------------------------
  // Output register and enable
  // ----------------------------------------------------------------------
  logic              clk_prev_q;
  logic              clk_prev_d;
  logic [DATA_W-1:0] master_q;
  logic [DATA_W-1:0] master_d;
  logic [DATA_W-1:0] slave_q;
  logic [DATA_W-1:0] slave_d;
  logic              drive_sync_q;
  logic              drive_sync_d;
  logic [DATA_W-1:0] out_q;
  logic [DATA_W-1:0] out_d;
  logic              oe_n_q;
  logic              oe_n_d;
  logic              reading;
  logic              edge_up;
  logic              init_act;
  logic              verify;

  always_comb begin
    reading      = (mode_q == PRP_MODE_READ) && !hv_s;
    clk_prev_d   = clkpgm_s;
    edge_up      = reading && clkpgm_s && !clk_prev_q;
    init_act     = reading && !init_n_s;
    verify       = (mode_q == PRP_MODE_INHIBIT) && !oe_n_s && !a1_hv_s;
    master_d     = mem_rdata;
    slave_d      = slave_q;
    drive_sync_d = drive_sync_q;
    if (init_act) begin
      master_d = init_word_q;
      slave_d  = init_word_q;
    end else if (edge_up) begin
      slave_d = master_q;
    end
    if (edge_up && !init_act) begin
      drive_sync_d = !oe_n_s;
    end
    out_d  = slave_d;
    oe_n_d = 1'b1;
    if (verify) begin
      out_d  = mem_rdata;
      oe_n_d = 1'b0;
    end else if (reading) begin
      if (sync_cell_q) begin
        oe_n_d = !drive_sync_d;
      end else begin
        oe_n_d = oe_n_s;
      end
    end
  end

  // Init held low keeps the extra word through any edge
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      clk_prev_q   <= `PRP_CLKPGM_IDLE;
      master_q     <= '0;
      slave_q      <= '0;
      drive_sync_q <= 1'b0;
      out_q        <= '0;
      oe_n_q       <= 1'b1;
    end else begin
      clk_prev_q   <= clk_prev_d;
      master_q     <= master_d;
      slave_q      <= slave_d;
      drive_sync_q <= drive_sync_d;
      out_q        <= out_d;
      oe_n_q       <= oe_n_d;
    end
  end

  assign REGISTERED_OUTPUTS_OUT      = out_q;
  assign REGISTERED_OUTPUTS_OE_N_OUT = oe_n_q;

endmodule

/* src/prp_params.svh */
// Constants for the registered PROM read port
`ifndef PRP_PARAMS_SVH
`define PRP_PARAMS_SVH

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define PRP_ADDR_W          11
`define PRP_DATA_W          8
`define PRP_DEPTH           2048

// ----------------------------------------------------------------------
// Erased contents of the array, the extra word and the mode cell
// ----------------------------------------------------------------------
`define PRP_ERASED_WORD     8'h00
`define PRP_INIT_WORD_RST   8'h00
`define PRP_SYNC_CELL_RST   1'b0

// ----------------------------------------------------------------------
// Address bit position used by the extra-word and mode-cell select
// ----------------------------------------------------------------------
`define PRP_SEL_BIT         2

// ----------------------------------------------------------------------
// Pin levels at rest: clock/program, enable and initialize high
// ----------------------------------------------------------------------
`define PRP_PIN_IDLE        5'b01110
`define PRP_CLKPGM_IDLE     1'b1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PRP_CLK_PERIOD_PS   4000
`define PRP_PGM_MIN_NS      100000
`define PRP_PGM_MIN_CYC     ((`PRP_PGM_MIN_NS * 1000 + `PRP_CLK_PERIOD_PS - 1) / `PRP_CLK_PERIOD_PS)

`endif

/* src/prp_pkg.sv */
// Types for the registered PROM read port
package prp_pkg;

  // --------------------------------------------------------------------
  // Pin mode of the device
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    PRP_MODE_READ    = 2'b00,
    PRP_MODE_INHIBIT = 2'b01,
    PRP_MODE_PULSE   = 2'b10
  } prp_mode_t;

endpackage

/* src/prp_array.sv */
// Word array with registered read and bit-setting write
`timescale 1ns/1ns
`include "prp_params.svh"

module prp_array #(
  parameter int ADDR_W = `PRP_ADDR_W,
  parameter int DATA_W = `PRP_DATA_W,
  parameter int DEPTH  = `PRP_DEPTH
) (
  input  wire logic              clk_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic      [DATA_W-1:0] rd_data_out,
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in
);

  logic [DATA_W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << ADDR_W)) begin
      $error("prp_array: depth exceeds address range");
    end
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = `PRP_ERASED_WORD;
    end
  end

  // ----------------------------------------------------------------------
  // Programming only turns zeros into ones
  // ----------------------------------------------------------------------
  // Plain always: the initial block also fills the array
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= mem[wr_addr_in] | wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule

/* testbench/prp_read_port_assertions.sv */
// Concurrent checks on the read port pins
`timescale 1ns/1ns
module prp_rp_chk (
  input wire logic        CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic [10:0] WORD_ADDRESS_IN,
  input wire logic        ADDR1_HIGHVOLT_IN,
  input wire logic        CLOCK_PROGRAM_PIN_IN,
  input wire logic        ENABLE_VERIFY_N_IN,
  input wire logic        PRESET_HIGHVOLT_PIN_IN,
  input wire logic        PROGRAMMING_HIGH_VOLTAGE_IN,
  input wire logic [7:0]  REGISTERED_OUTPUTS_OUT,
  input wire logic        REGISTERED_OUTPUTS_OE_N_OUT
);
  wire logic       hv    = PROGRAMMING_HIGH_VOLTAGE_IN;
  wire logic       en_n  = ENABLE_VERIFY_N_IN;
  wire logic       ini_n = PRESET_HIGHVOLT_PIN_IN;
  wire logic       pin   = CLOCK_PROGRAM_PIN_IN;
  wire logic [7:0] dq    = REGISTERED_OUTPUTS_OUT;
  wire logic       oe_n  = REGISTERED_OUTPUTS_OE_N_OUT;
  logic            cell_d;
  logic            cell_q;
  // ----------------------------------------
  // Mode cell tracking
  // ----------------------------------------
  // Set at a mode-cell pulse so checks split by enable mode
  assign cell_d = cell_q | (hv & ADDR1_HIGHVOLT_IN & WORD_ADDRESS_IN[2] & ~pin);
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cell_q <= 1'h0;
    end else begin
      cell_q <= cell_d;
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_rise;
    $rose(pin) && !hv && ini_n && cell_q;
  endsequence
  sequence s_idle;
    oe_n && dq == 8'h00;
  endsequence
  reset_state_a: assert property (
    $rose(RST_N_IN) |-> s_idle ##1 s_idle) else $error("outputs not idle after reset");
  inhibit_float_a: assert property (
    (hv && en_n)[*6] |-> oe_n) else $error("outputs driven in inhibit");
  init_hold_a: assert property (
    (!ini_n && !hv)[*6] |-> $stable(dq)) else $error("word moved while initialize low");
  out_hold_a: assert property (
    (ini_n && !hv && !$rose(pin))[*8] |-> $stable(dq)) else $error("output moved between edges");
  async_float_a: assert property (
    (en_n && !hv && !cell_q)[*6] |-> oe_n) else $error("async enable high not floating");
  async_drive_a: assert property (
    (!en_n && !hv && !cell_q)[*6] |-> !oe_n) else $error("async enable low not driving");
  sync_hold_a: assert property (
    (cell_q && !hv && !$rose(pin))[*8] |-> $stable(oe_n)) else $error("sync enable moved off edge");
  sync_float_a: assert property (
    s_rise ##0 en_n |-> ##[2:6] oe_n) else $error("sync enable high not floating");
  sync_drive_a: assert property (
    s_rise ##0 !en_n |-> ##[2:6] !oe_n) else $error("sync enable low not driving");
endmodule
bind prp_read_port prp_rp_chk i_chk (.*);

/* testbench/prp_seq_model.sv */
// Sequencer and programmer model driving the clock/program pin
`timescale 1ns/1ns
module prp_seq_model (
  input  wire logic clk_in,
  output logic      pin_out
);
  initial pin_out = 1'h1;
  // Low phase then rise; a long low phase is a program pulse
  task automatic pulse(input int n);
    @(posedge clk_in);
    pin_out <= 1'h0;
    repeat (n) @(posedge clk_in);
    pin_out <= 1'h1;
    repeat (6) @(posedge clk_in);
  endtask
endmodule

/* testbench/registered_prom_read_port_tb_top.sv */
// Self-checking testbench for the registered PROM read port
`timescale 1ns/1ns
`define CHK(n, e, a) begin #1; num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module registered_prom_read_port_tb_top;
  logic        clk = 1'h0;
  logic        rst_n;
  logic [10:0] addr;
  logic        a1hv;
  logic        en_n;
  logic        init_n;
  logic        hv;
  logic [7:0]  wdata;
  logic [7:0]  dout;
  logic [7:0]  dbus;
  logic        oe_n;
  logic        pin;
  int          err_count = 0;
  int          num_checks = 0;
  always #2 clk = ~clk;
  // Data pins: device drives when enabled, else the programmer
  assign dbus = oe_n ? wdata : dout;
  prp_seq_model i_seq (.clk_in(clk), .pin_out(pin));
  prp_read_port #(.PGM_MIN_CYC(4)) i_dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .WORD_ADDRESS_IN(addr),
    .ADDR1_HIGHVOLT_IN(a1hv), .CLOCK_PROGRAM_PIN_IN(pin), .ENABLE_VERIFY_N_IN(en_n),
    .PRESET_HIGHVOLT_PIN_IN(init_n), .PROGRAMMING_HIGH_VOLTAGE_IN(hv),
    .REGISTERED_OUTPUTS_IN(dbus), .REGISTERED_OUTPUTS_OUT(dout),
    .REGISTERED_OUTPUTS_OE_N_OUT(oe_n));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic prog(input logic [10:0] a, input logic sel, input logic [7:0] d, input int n);
    w(1);
    addr <= a;
    a1hv <= sel;
    wdata <= d;
    w(2);
    i_seq.pulse(n);
  endtask
  task automatic verify(input logic [10:0] a, input logic [7:0] e);
    w(1);
    addr <= a;
    a1hv <= 1'h0;
    en_n <= 1'h0;
    w(8);
    `CHK("verify data", e, dout)
    w(1);
    en_n <= 1'h1;
    w(6);
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    w(1);
    addr <= a;
    i_seq.pulse(5);
    `CHK("read data", e, dout)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_init_blank();
    w(4);
    `CHK("oe_n", 1'h1, oe_n)
    w(1);
    init_n <= 1'h0;
    en_n <= 1'h0;
    w(8);
    `CHK("blank word", 8'h00, dout)
    `CHK("oe_n", 1'h0, oe_n)
    w(1);
    en_n <= 1'h1;
    init_n <= 1'h1;
  endtask
  task automatic t_program();
    w(1);
    hv <= 1'h1;
    w(6);
    `CHK("inhibit oe_n", 1'h1, oe_n)
    prog(11'h000, 1'h0, 8'h5a, 8);
    prog(11'h000, 1'h0, 8'h0f, 8);
    prog(11'h7ff, 1'h0, 8'h81, 8);
    // Short pulse must leave the word erased
    prog(11'h001, 1'h0, 8'hff, 3);
    prog(11'h000, 1'h1, 8'ha5, 8);
    verify(11'h000, 8'h5f);
    verify(11'h7ff, 8'h81);
    w(1);
    hv <= 1'h0;
    w(6);
  endtask
  task automatic t_read();
    w(1);
    en_n <= 1'h0;
    rd(11'h7ff, 8'h81);
    rd(11'h001, 8'h00);
    rd(11'h000, 8'h5f);
    w(1);
    en_n <= 1'h1;
    w(6);
    `CHK("async float", 1'h1, oe_n)
    w(1);
    en_n <= 1'h0;
    w(6);
    `CHK("async drive", 1'h0, oe_n)
    `CHK("held word", 8'h5f, dout)
  endtask
  task automatic t_init();
    w(1);
    addr <= 11'h7ff;
    init_n <= 1'h0;
    w(6);
    `CHK("init word", 8'ha5, dout)
    i_seq.pulse(5);
    `CHK("init over edge", 8'ha5, dout)
    w(1);
    init_n <= 1'h1;
    w(6);
    `CHK("init released", 8'ha5, dout)
    rd(11'h7ff, 8'h81);
  endtask
  task automatic t_sync();
    w(1);
    hv <= 1'h1;
    a1hv <= 1'h1;
    addr <= 11'h004;
    w(6);
    i_seq.pulse(8);
    w(1);
    hv <= 1'h0;
    a1hv <= 1'h0;
    en_n <= 1'h1;
    addr <= 11'h7ff;
    w(6);
    i_seq.pulse(5);
    `CHK("sync float", 1'h1, oe_n)
    w(1);
    en_n <= 1'h0;
    w(6);
    `CHK("sync still float", 1'h1, oe_n)
    rd(11'h7ff, 8'h81);
    `CHK("sync drive", 1'h0, oe_n)
    w(1);
    en_n <= 1'h1;
    w(6);
    `CHK("sync still drive", 1'h0, oe_n)
    i_seq.pulse(5);
    `CHK("sync float again", 1'h1, oe_n)
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    rst_n  <= 1'h0;
    addr   <= 11'h000;
    a1hv   <= 1'h0;
    en_n   <= 1'h1;
    init_n <= 1'h1;
    hv     <= 1'h0;
    wdata  <= 8'h00;
    w(3);
    rst_n <= 1'h1;
    t_init_blank();
    t_program();
    t_read();
    t_init();
    t_sync();
    give_verdict();
  end
  // Tests need about 320 cycles
  initial begin
    w(4000);
    err_count++;
    give_verdict();
  end
endmodule
